// ### logic/dshc_pkg.sv
// package for deep sleep / hibernate power control
package dshc_pkg;
	localparam int REGULATOR_FREQUENCY_FIELD_W             = 2;
	localparam int GAIN_W             = 4;
	localparam int LEVEL_W            = 4;
	localparam logic [1:0] REGULATOR_FREQUENCY_FIELD_OFF   = 2'h0;
	localparam logic [1:0] REGULATOR_FREQUENCY_FIELD_RST   = 2'h3;
	localparam logic [3:0] LEVEL_RST  = 4'h9;
	localparam logic [3:0] GAIN_RST   = 4'h0;
	localparam int LEVEL_STEP_MV      = 50;
	localparam int CLK_MHZ            = 20;
	localparam int SETTLE_US          = 100;
	localparam int SETTLE_CYC         = SETTLE_US * CLK_MHZ;
	localparam int RESET_HOLD_CYC     = 16;

	typedef enum logic [2:0] {
		DSHC_FULLON,
		DSHC_ACTIVE,
		DSHC_DEEP,
		DSHC_HIBER,
		DSHC_RAMP,
		DSHC_RESET
	} dshc_mode_t;

	// voltage regulator control contents, kept across hibernate except the frequency field, reset on wake
	typedef struct packed {
		logic               wakeCan;
		logic               wakePin;
		logic               wakeRtc;
		logic               sdramCkeHoldLow;
		logic               bypass;
		logic [LEVEL_W-1:0] level;
		logic [GAIN_W-1:0]  gain;
		logic [REGULATOR_FREQUENCY_FIELD_W-1:0]  regulator_frequency_field;
	} dshc_vrctl_t;

	typedef struct packed {
		logic canWake;
		logic pinWake;
		logic rtcWake;
		logic rtcIrq;
	} dshc_events_t;

	localparam dshc_vrctl_t VRCTL_RST = '{
		wakeCan: 1'b0, wakePin: 1'b0, wakeRtc: 1'b0, sdramCkeHoldLow: 1'b0,
		bypass: 1'b0, level: LEVEL_RST, gain: GAIN_RST, regulator_frequency_field: REGULATOR_FREQUENCY_FIELD_RST};
endpackage : dshc_pkg

// ### logic/dshc_deep_sleep_hibernate_control.sv
// deep sleep and hibernate power-mode sequencer
//
// Operation
// R1 - deep sleep stops core and system clocks
// R2 - deep sleep denies async peripherals resource access
// R3 - leave deep sleep only by reset/rtc irq
// R4 - rtc irq in deep sleep goes active
// R5 - reset in deep sleep resets, then full-on
// R6 - frequency field zero enters hibernate, supply off
// R7 - hibernate tri-states external pins
// R8 - can wake-up restarts regulator
// R9 - low general wake pin requests wake-up
// R10 - rtc event or reset restarts regulator
// R11 - every hibernate wake runs hardware reset
// R12 - each wake source needs its enable; the reset pin wakes without one
// R13 - control register survives hibernate
// R14 - hold sdram clock enable low on wake
// R15 - supply level steps of 50 mV
// R16 - regulator may be disabled and bypassed
// R17 - wakes async-caught, gated, reset until stable
`timescale 1ns/10ps
module dshc_deep_sleep_hibernate_control
	import dshc_pkg::*;
#(
	parameter int SETTLE_CYCLES = SETTLE_CYC
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         porRst,
	input  wire logic         resetPinN,
	input  wire logic         general_wake_n,
	input  wire logic         canWakeReq,
	input  wire logic         rtcWakeEvt,
	input  wire logic         rtcAsyncIrq,
	input  wire logic         deepSleepReq,
	input  wire logic         otherWakeEvt,
	input  wire logic         vrctlWrite,
	input  wire dshc_vrctl_t  vrctlWdata,
	input  wire logic         bypassStrap,
	output logic              core_clock_en,
	output logic              sysClockEn,
	output logic              asyncAccessEn,
	output logic              regulatorOn,
	output logic [LEVEL_W-1:0] internal_supply_level,
	output logic [11:0]       internalSupplyMv,
	output logic              pinDriveEn,
	output logic              sdram_clock_enable,
	output logic              procResetOut,
	output dshc_vrctl_t       voltage_regulator_control,
	output dshc_mode_t        powerMode
);

	localparam int CNT_W = $clog2(SETTLE_CYCLES + RESET_HOLD_CYC + 1);

	typedef struct packed {
		dshc_mode_t   mode;
		dshc_mode_t   afterReset;
		dshc_vrctl_t  vrctl;
		logic [2:0]   rstSync;
		logic [2:0]   gpwSync;
		logic [2:0]   canSync;
		logic [2:0]   rtcSync;
		logic [2:0]   irqSync;
		logic         bypassSeen;
		logic [CNT_W-1:0] cnt;
		logic         coreEn;
		logic         sysEn;
		logic         asyncEn;
		logic         regOn;
		logic         pinsEn;
		logic         cke;
		logic         procRst;
		logic [11:0]  mv;
	} dshc_state_t;

	dshc_state_t s_q;
	dshc_state_t s_d;

	function automatic logic agreed(input logic [2:0] sh);
		return sh[1] & sh[2];
	endfunction : agreed

	function automatic logic [11:0] levelToMv(input logic [LEVEL_W-1:0] lvl);
		// 50 mV per step on top of a fixed floor
		return 12'(12'h2bc + 12'(lvl) * 12'(LEVEL_STEP_MV)); // R15
	endfunction : levelToMv

	// cke level while the supply ramps and reset is held
	function automatic logic wakeCke(input dshc_vrctl_t vr);
		return ~vr.sdramCkeHoldLow; // R14
	endfunction : wakeCke

	// entry into the reset hold, shared by the full-on/active and deep sleep reset-pin paths
	function automatic dshc_state_t enterReset(input dshc_state_t st);
		dshc_state_t r;
		r = st;
		r.mode = DSHC_RESET;
		r.afterReset = DSHC_FULLON;
		r.cnt = '0;
		r.procRst = 1'b1;
		// drop cke at once when sdramCkeHoldLow is set, so a self-refreshing sdram never sees a glitch
		r.cke = wakeCke(st.vrctl); // R14
		return r;
	endfunction : enterReset

	logic rstLow;
	logic gpwLow;
	logic canEvt;
	logic rtcEvt;
	logic irqEvt;
	logic hibWake;
	dshc_events_t seenEvt;
	dshc_events_t armedEvt;

	always_comb begin
		rstLow = agreed(s_q.rstSync);
		gpwLow = agreed(s_q.gpwSync);
		canEvt = agreed(s_q.canSync);
		rtcEvt = agreed(s_q.rtcSync);
		irqEvt = agreed(s_q.irqSync);
		// reset pin needs no enable: it must always bring the part back
		hibWake = armedEvt.canWake   // R8 R12 R17
			| armedEvt.pinWake       // R9 R12 R17
			| armedEvt.rtcWake       // R10 R12
			| rstLow;                // R10
	end

	// synced levels gathered, then the three wake sources masked by the retained enables
	always_comb begin
		seenEvt.canWake = canEvt;
		seenEvt.pinWake = gpwLow;
		seenEvt.rtcWake = rtcEvt;
		seenEvt.rtcIrq = irqEvt;
		armedEvt.canWake = seenEvt.canWake & s_q.vrctl.wakeCan; // R8 R12
		armedEvt.pinWake = seenEvt.pinWake & s_q.vrctl.wakePin; // R9 R12
		armedEvt.rtcWake = seenEvt.rtcWake & s_q.vrctl.wakeRtc; // R10 R12
		// the interrupt only matters in deep sleep, never gated
		armedEvt.rtcIrq = seenEvt.rtcIrq; // R3
	end

	always_comb begin
		s_d = s_q;
		// pins sampled through three flops, second and third must agree
		s_d.rstSync = {s_q.rstSync[1:0], ~resetPinN};
		s_d.gpwSync = {s_q.gpwSync[1:0], ~general_wake_n}; // R9
		s_d.canSync = {s_q.canSync[1:0], canWakeReq};
		s_d.rtcSync = {s_q.rtcSync[1:0], rtcWakeEvt};
		s_d.irqSync = {s_q.irqSync[1:0], rtcAsyncIrq};
		s_d.mv = levelToMv(s_q.vrctl.level); // R15

		unique case (s_q.mode)
			DSHC_FULLON, DSHC_ACTIVE: begin
				s_d.coreEn = 1'b1;
				s_d.sysEn = 1'b1;
				s_d.asyncEn = 1'b1;
				s_d.regOn = ~s_q.vrctl.bypass; // R16
				s_d.pinsEn = 1'b1;
				s_d.cke = 1'b1;
				s_d.procRst = 1'b0;
				if (rstLow) begin
					s_d = enterReset(s_d); // R5
				end else if (vrctlWrite) begin
					s_d.vrctl = vrctlWdata;
					if (vrctlWdata.regulator_frequency_field == REGULATOR_FREQUENCY_FIELD_OFF) begin
						s_d.mode = DSHC_HIBER; // R6
						s_d.coreEn = 1'b0; // R6
						s_d.sysEn = 1'b0;
						s_d.asyncEn = 1'b0;
						s_d.regOn = 1'b0; // R6
						s_d.pinsEn = 1'b0; // R7
						s_d.cke = ~vrctlWdata.sdramCkeHoldLow; // R14
					end
				end else if (deepSleepReq) begin
					s_d.mode = DSHC_DEEP;
					s_d.coreEn = 1'b0; // R1
					s_d.sysEn = 1'b0; // R1
					s_d.asyncEn = 1'b0; // R2
				end
			end
			DSHC_DEEP: begin
				// otherWakeEvt deliberately unused here: only two exits
				s_d.coreEn = 1'b0; // R1
				s_d.sysEn = 1'b0; // R1
				s_d.asyncEn = 1'b0; // R2
				if (rstLow) begin // R3
					s_d = enterReset(s_d); // R5
				end else if (irqEvt) begin // R3
					s_d.mode = DSHC_ACTIVE; // R4
					s_d.coreEn = 1'b1;
					s_d.sysEn = 1'b1;
					s_d.asyncEn = 1'b1;
				end
			end
			DSHC_HIBER: begin
				s_d.coreEn = 1'b0;
				s_d.sysEn = 1'b0;
				s_d.asyncEn = 1'b0;
				s_d.regOn = 1'b0;
				s_d.pinsEn = 1'b0; // R7
				s_d.cke = s_q.cke;
				if (hibWake) begin
					s_d.mode = DSHC_RAMP; // R11
					s_d.regOn = ~s_q.vrctl.bypass; // R8 R10 R16
					s_d.procRst = 1'b1; // R11 R17
					s_d.cnt = '0;
					s_d.afterReset = DSHC_FULLON;
					s_d.vrctl.regulator_frequency_field = REGULATOR_FREQUENCY_FIELD_RST;
				end
			end
			DSHC_RAMP: begin
				// reset stays active until the supply settles
				s_d.procRst = 1'b1; // R17
				s_d.cke = wakeCke(s_q.vrctl); // R14
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt == CNT_W'(SETTLE_CYCLES - 1)) begin // R17
					s_d.mode = DSHC_RESET; // R11
					s_d.cnt = '0;
				end
			end
			DSHC_RESET: begin
				s_d.procRst = 1'b1; // R5 R11
				s_d.pinsEn = 1'b1;
				s_d.regOn = ~s_q.vrctl.bypass;
				s_d.cke = wakeCke(s_q.vrctl); // R14
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt >= CNT_W'(RESET_HOLD_CYC - 1) && !rstLow) begin
					s_d.mode = s_q.afterReset; // R5
					s_d.procRst = 1'b0;
					s_d.coreEn = 1'b1;
					s_d.sysEn = 1'b1;
					s_d.asyncEn = 1'b1;
					s_d.cke = 1'b1;
					s_d.cnt = '0;
				end
			end
			default: begin
				s_d.mode = DSHC_RESET;
				s_d.cnt = '0;
			end
		endcase
		// strap read once per hard reset; later reset-pin holds keep the bit
		if (s_q.mode == DSHC_RESET && !s_q.bypassSeen) begin
			s_d.bypassSeen = 1'b1;
			if (bypassStrap) begin
				s_d.vrctl.bypass = 1'b1; // R16
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst || porRst) begin
			s_q.mode <= DSHC_RESET;
			s_q.afterReset <= DSHC_FULLON;
			// power-on loads VRCTL_RST into the control register; srst alone keeps it
			s_q.vrctl <= porRst ? VRCTL_RST : s_q.vrctl; // R13
			s_q.rstSync <= '0;
			s_q.gpwSync <= '0;
			s_q.canSync <= '0;
			s_q.rtcSync <= '0;
			s_q.irqSync <= '0;
			s_q.bypassSeen <= 1'b0;
			s_q.cnt <= '0;
			s_q.coreEn <= 1'b0;
			s_q.sysEn <= 1'b0;
			s_q.asyncEn <= 1'b0;
			s_q.regOn <= 1'b1;
			s_q.pinsEn <= 1'b1;
			s_q.cke <= 1'b0;
			s_q.procRst <= 1'b1;
			s_q.mv <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		core_clock_en = s_q.coreEn;
		sysClockEn = s_q.sysEn;
		asyncAccessEn = s_q.asyncEn;
		regulatorOn = s_q.regOn;
		internal_supply_level = s_q.vrctl.level;
		internalSupplyMv = s_q.mv;
		pinDriveEn = s_q.pinsEn;
		sdram_clock_enable = s_q.cke;
		procResetOut = s_q.procRst;
		voltage_regulator_control = s_q.vrctl;
		powerMode = s_q.mode;
	end

endmodule : dshc_deep_sleep_hibernate_control

// ### bench/dshc_wake_src.sv
// wake and reset source model on the far side of the sequencer
`timescale 1ns/10ps
module dshc_wake_src (
	input wire logic [4:0] src,
	output logic canWakeReq,
	output logic general_wake_n,
	output logic rtcWakeEvt,
	output logic resetPinN,
	output logic rtcAsyncIrq
);
	// levels follow the request at once, no clock needed
	assign canWakeReq = src[0];
	assign general_wake_n = !src[1];
	assign rtcWakeEvt = src[2];
	assign resetPinN = !src[3];
	assign rtcAsyncIrq = src[4];
endmodule : dshc_wake_src

// ### bench/dshc_deep_sleep_hibernate_control_sva.sv
// port assertions for the power-mode sequencer
`timescale 1ns/10ps
module dshc_deep_sleep_hibernate_control_sva
	import dshc_pkg::*;
(
	input wire logic               clk,
	input wire logic               srst,
	input wire logic               porRst,
	input wire logic               vrctlWrite,
	input wire logic               core_clock_en,
	input wire logic               sysClockEn,
	input wire logic               asyncAccessEn,
	input wire logic               regulatorOn,
	input wire logic               pinDriveEn,
	input wire logic               sdram_clock_enable,
	input wire logic               procResetOut,
	input wire logic [LEVEL_W-1:0] internal_supply_level,
	input wire logic [11:0]        internalSupplyMv,
	input wire dshc_vrctl_t        vrctlWdata,
	input wire dshc_vrctl_t        voltage_regulator_control,
	input wire dshc_mode_t         powerMode
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst || porRst);
	sequence sDeepLeave;
		powerMode == DSHC_DEEP ##1 powerMode != DSHC_DEEP;
	endsequence
	sequence sHibLeave;
		powerMode == DSHC_HIBER ##1 powerMode != DSHC_HIBER;
	endsequence
	chk_deep_clocks: assert property (powerMode == DSHC_DEEP |-> !core_clock_en && !sysClockEn)
		else $error("clock runs in deep sleep");
	chk_deep_access: assert property (powerMode == DSHC_DEEP |-> !asyncAccessEn)
		else $error("access open in deep sleep");
	chk_deep_exit: assert property (sDeepLeave |-> powerMode inside {DSHC_ACTIVE, DSHC_RESET})
		else $error("bad deep sleep exit");
	chk_regulator_frequency_field_off: assert property (vrctlWrite && vrctlWdata.regulator_frequency_field == REGULATOR_FREQUENCY_FIELD_OFF &&
		powerMode inside {DSHC_FULLON, DSHC_ACTIVE} |=> powerMode == DSHC_HIBER)
		else $error("no hibernate entry");
	chk_hib_pins: assert property (powerMode == DSHC_HIBER |->
		!pinDriveEn && !regulatorOn && !core_clock_en) else $error("pins driven in hibernate");
	chk_hib_wake: assert property (sHibLeave |-> powerMode == DSHC_RAMP && procResetOut)
		else $error("wake without reset");
	chk_cke_hold: assert property (powerMode inside {DSHC_RAMP, DSHC_RESET} &&
		voltage_regulator_control.sdramCkeHoldLow |-> !sdram_clock_enable)
		else $error("sdram cke raised");
	chk_level_mv: assert property ($stable(internal_supply_level) [*2] |->
		internalSupplyMv == 12'(700 + LEVEL_STEP_MV * internal_supply_level))
		else $error("supply millivolts wrong");
endmodule : dshc_deep_sleep_hibernate_control_sva
bind dshc_deep_sleep_hibernate_control dshc_deep_sleep_hibernate_control_sva u_sva (.clk,
	.srst, .porRst, .vrctlWrite, .core_clock_en, .sysClockEn, .asyncAccessEn, .regulatorOn,
	.pinDriveEn, .sdram_clock_enable, .procResetOut, .internal_supply_level,
	.internalSupplyMv, .vrctlWdata, .voltage_regulator_control, .powerMode);

// ### bench/dshc_deep_sleep_hibernate_control_test.sv
// self-checking bench for the power-mode sequencer
`timescale 1ns/10ps
module dshc_deep_sleep_hibernate_control_test;
	import dshc_pkg::*;
	logic clk = 0, srst = 1, porRst = 1, deepSleepReq = 0, otherWakeEvt = 0, vrctlWrite = 0;
	logic bypassStrap = 0, core_clock_en, sysClockEn, asyncAccessEn, regulatorOn, pinDriveEn;
	logic sdram_clock_enable, procResetOut, resetPinN, general_wake_n, canWakeReq;
	logic rtcWakeEvt, rtcAsyncIrq;
	logic [4:0] src = 5'h0;
	logic [LEVEL_W-1:0] internal_supply_level;
	logic [11:0] internalSupplyMv;
	dshc_vrctl_t vrctlWdata = VRCTL_RST, voltage_regulator_control;
	dshc_mode_t powerMode;
	int errorCnt = 0, cmpCount = 0, cyc = 0;
	initial forever #25 clk = ~clk;
	dshc_wake_src u_src (.src, .canWakeReq, .general_wake_n, .rtcWakeEvt, .resetPinN,
		.rtcAsyncIrq);
	dshc_deep_sleep_hibernate_control #(.SETTLE_CYCLES(8)) u_dut (.clk, .srst, .porRst,
		.resetPinN, .general_wake_n, .canWakeReq, .rtcWakeEvt, .rtcAsyncIrq, .deepSleepReq,
		.otherWakeEvt, .vrctlWrite, .vrctlWdata, .bypassStrap, .core_clock_en, .sysClockEn,
		.asyncAccessEn, .regulatorOn, .internal_supply_level, .internalSupplyMv, .pinDriveEn,
		.sdram_clock_enable, .procResetOut, .voltage_regulator_control, .powerMode);
	task chk(input logic [31:0] seen, exp);
		cmpCount++;
		if (seen !== exp) begin
			errorCnt++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wm(input dshc_mode_t m);
		for (int i = 0; i < 60 && powerMode !== m; i++) @(negedge clk);
		chk(powerMode, m);
	endtask : wm
	task wr(input dshc_vrctl_t v);
		vrctlWdata = v;
		vrctlWrite = 1;
		@(negedge clk) vrctlWrite = 0;
		@(negedge clk);
	endtask : wr
	task goDeep;
		deepSleepReq = 1;
		@(negedge clk) deepSleepReq = 0;
		wm(DSHC_DEEP);
	endtask : goDeep
	task tDeep;
		goDeep();
		chk({core_clock_en, sysClockEn, asyncAccessEn}, 3'h0);
		src = 5'h07;
		otherWakeEvt = 1;
		repeat (6) @(negedge clk);
		chk(powerMode, DSHC_DEEP);
		{src, otherWakeEvt} = 6'h20;
		wm(DSHC_ACTIVE);
		chk({core_clock_en, sysClockEn}, 2'h3);
		src = 5'h00;
		// let the synced interrupt drain before sleeping again
		repeat (4) @(negedge clk);
		goDeep();
		src = 5'h08;
		repeat (6) @(negedge clk);
		chk(procResetOut, 1'b1);
		src = 5'h00;
		wm(DSHC_FULLON);
		$display("deep sleep test done");
	endtask : tDeep
	task tHib;
		dshc_vrctl_t v;
		for (int i = 0; i < 4; i++) begin
			v = VRCTL_RST;
			v.regulator_frequency_field = REGULATOR_FREQUENCY_FIELD_OFF;
			v.sdramCkeHoldLow = i[0];
			{v.wakeCan, v.wakePin, v.wakeRtc} = {i == 0, i == 1, i == 2};
			wr(v);
			chk({powerMode, pinDriveEn, regulatorOn, sdram_clock_enable}, {DSHC_HIBER, 2'h0, !i[0]});
			src = ~(5'h1 << i) & 5'h07;
			repeat (6) @(negedge clk);
			chk(powerMode, DSHC_HIBER);
			src = 5'h1 << i;
			wm(DSHC_RAMP);
			chk({procResetOut, sdram_clock_enable}, {1'b1, !i[0]});
			src = 5'h00;
			wm(DSHC_FULLON);
			chk(voltage_regulator_control, {v[14:2], REGULATOR_FREQUENCY_FIELD_RST});
		end
		$display("hibernate test done");
	endtask : tHib
	task tLvl;
		wr('{wakeCan: 0, wakePin: 0, wakeRtc: 0, sdramCkeHoldLow: 0, bypass: 1, level: 4'h5,
			gain: GAIN_RST, regulator_frequency_field: REGULATOR_FREQUENCY_FIELD_RST});
		chk(internalSupplyMv, 12'(700 + LEVEL_STEP_MV * 5));
		chk(internal_supply_level, 4'h5);
		chk(regulatorOn, 1'b0);
		$display("level test done");
	endtask : tLvl
	task tRst;
		// mid-run sync reset keeps the control word and reads the strap
		bypassStrap = 1;
		srst = 1;
		repeat (2) @(negedge clk);
		srst = 0;
		wm(DSHC_FULLON);
		bypassStrap = 0;
		chk(voltage_regulator_control.sdramCkeHoldLow, 1'b1);
		chk({voltage_regulator_control.bypass, regulatorOn}, 2'h2);
		$display("reset retention test done");
	endtask : tRst
	task close_out;
		$display("compares %0d mismatches %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	// hang guard, far above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errorCnt++;
			close_out();
		end
	end
	initial begin
		repeat (20) @(negedge clk);
		{srst, porRst} = 2'h0;
		wm(DSHC_FULLON);
		chk(voltage_regulator_control, VRCTL_RST);
		tDeep();
		tHib();
		tRst();
		tLvl();
		close_out();
	end
endmodule : dshc_deep_sleep_hibernate_control_test
